// *** hw/pmv_regs.vh ***
// Offsets, field positions, reset values and timing counts for the program memory unit
`ifndef PMV_REGS_VH
`define PMV_REGS_VH

// Wishbone register byte addresses
`define PMV_OFF_CTRL        8'h00
`define PMV_OFF_STATUS      8'h04
`define PMV_OFF_PC          8'h08
`define PMV_OFF_TBL_PTR     8'h0c
`define PMV_OFF_TBL_HIGH    8'h10
`define PMV_OFF_PROG_ADDR   8'h14
`define PMV_OFF_PROG_DATA   8'h18
`define PMV_OFF_DMEM_ADDR   8'h1c
`define PMV_OFF_DMEM_DATA   8'h20
`define PMV_OFF_INSTR       8'h24
`define PMV_OFF_LAST_WORD   8'h28

// Control register fields
`define PMV_CTRL_RUN        0
`define PMV_CTRL_EXT_EN     1
`define PMV_CTRL_TMR0_EN    2
`define PMV_CTRL_TMR1_EN    3
`define PMV_CTRL_ADC_EN     4
`define PMV_CTRL_GIE        5
`define PMV_CTRL_W          6
`define PMV_CTRL_RESET      6'h00

// Instruction register fields
`define PMV_INSTR_LAST_BIT  8
`define PMV_INSTR_GO_BIT    9

// Fixed entry points
`define PMV_VEC_RESET       12'h000
`define PMV_VEC_EXT         12'h004
`define PMV_VEC_TMR0        12'h008
`define PMV_VEC_TMR1        12'h00c
`define PMV_VEC_ADC         12'h010
`define PMV_LAST_PAGE       4'hf

// Data memory layout
`define PMV_SFR_TBL_PTR     8'h07
`define PMV_SFR_TBL_HIGH    8'h08
`define PMV_SFR_END         8'h24

// Instruction cycle is four system clocks
`define PMV_PHASES          4
`define PMV_TBL_CYCLES      2

`endif

// *** hw/pmv_cycle_gen.v ***
// Instruction-cycle enable divider
`timescale 1ns/1ps
module pmv_cycle_gen #(
   parameter DIV = 4
) (
   input  wire clock_i,
   input  wire rst_n_i,
   output wire tick_o
);
   reg [7:0] cnt_reg;
   wire      last = (cnt_reg == DIV[7:0] - 8'h01);

   always @(posedge clock_i) begin
      if (!rst_n_i)
         cnt_reg <= 8'h00;
      else if (last)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= cnt_reg + 8'h01;
   end

   assign tick_o = last;
endmodule

// *** hw/pmv_core.v ***
// Program memory, entry vectors, table read and data memory unit
`timescale 1ns/1ps
`include "pmv_regs.vh"

module pmv_core #(
   parameter PC_W   = 12,
   parameter WORD_W = 15,
   parameter DMEM_N = 192
) (
   input  wire             clock_i,
   input  wire             rst_n_i,
   input  wire [7:0]       wb_adr_i,
   input  wire [31:0]      wb_dat_i,
   input  wire [3:0]       wb_sel_i,
   input  wire             wb_we_i,
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   output reg  [31:0]      wb_dat_o,
   output reg              wb_ack_o,
   input  wire             ext_int_n_i,
   input  wire             tmr0_ovf_i,
   input  wire             tmr1_ovf_i,
   input  wire             adc_done_i,
   input  wire             stack_full_i,
   input  wire             stack_pop_i,
   output reg              int_ack_o,
   output reg  [PC_W-1:0]  fetch_addr_o,
   output reg  [WORD_W-1:0] fetch_word_o,
   output reg              fetch_valid_o
);
   localparam ST_FETCH = 2'd0;
   localparam ST_TBL   = 2'd1;

   reg [WORD_W-1:0] prog_mem [0:(1<<PC_W)-1];
   reg [7:0]        dmem [0:DMEM_N-1];

   reg [1:0]        state_reg;
   reg [PC_W-1:0]   pc_reg;
   reg [5:0]        ctrl_reg;
   reg [7:0]        tbl_ptr_reg;
   reg [7:0]        tbl_high_reg;
   reg [PC_W-1:0]   prog_addr_reg;
   reg [7:0]        dmem_addr_reg;
   reg [7:0]        instr_reg;
   reg              instr_last_reg;
   reg              instr_pend_reg;
   reg [PC_W-1:0]   tbl_addr_reg;
   reg [WORD_W-1:0] last_word_reg;
   reg [3:0]        pend_reg;
   reg [3:0]        pend_next;
   reg [3:0]        fired;
   reg              ext_s1_reg;
   reg              ext_s2_reg;
   reg              ext_prev_reg;
   reg              t0_s1_reg;
   reg              t0_s2_reg;
   reg              t0_prev_reg;
   reg              t1_s1_reg;
   reg              t1_s2_reg;
   reg              t1_prev_reg;
   reg              ad_s1_reg;
   reg              ad_s2_reg;
   reg              ad_prev_reg;
   reg              full_s1_reg;
   reg              full_s2_reg;
   reg              pop_s1_reg;
   reg              pop_s2_reg;
   reg              pop_prev_reg;
   reg [PC_W-1:0]   vec;
   reg [3:0]        take;

   wire             tick;
   wire             wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire             wr = wb_req & wb_we_i;
   wire             run = ctrl_reg[`PMV_CTRL_RUN];
   wire [7:0]       gp_idx = dmem_addr_reg - `PMV_SFR_END;
   wire             gp_hit = (dmem_addr_reg >= `PMV_SFR_END) &&
                             (gp_idx < DMEM_N);

   pmv_cycle_gen #(
      .DIV     (`PMV_PHASES)
   ) u_cycle (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .tick_o  (tick)
   );

   // Pin-side inputs pass two flops before edge detection
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         ext_s1_reg   <= 1'b1;
         ext_s2_reg   <= 1'b1;
         ext_prev_reg <= 1'b1;
         t0_s1_reg    <= 1'b0;
         t0_s2_reg    <= 1'b0;
         t0_prev_reg  <= 1'b0;
         t1_s1_reg    <= 1'b0;
         t1_s2_reg    <= 1'b0;
         t1_prev_reg  <= 1'b0;
         ad_s1_reg    <= 1'b0;
         ad_s2_reg    <= 1'b0;
         ad_prev_reg  <= 1'b0;
         full_s1_reg  <= 1'b0;
         full_s2_reg  <= 1'b0;
         pop_s1_reg   <= 1'b0;
         pop_s2_reg   <= 1'b0;
         pop_prev_reg <= 1'b0;
      end else begin
         ext_s1_reg   <= ext_int_n_i;
         ext_s2_reg   <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
         t0_s1_reg    <= tmr0_ovf_i;
         t0_s2_reg    <= t0_s1_reg;
         t0_prev_reg  <= t0_s2_reg;
         t1_s1_reg    <= tmr1_ovf_i;
         t1_s2_reg    <= t1_s1_reg;
         t1_prev_reg  <= t1_s2_reg;
         ad_s1_reg    <= adc_done_i;
         ad_s2_reg    <= ad_s1_reg;
         ad_prev_reg  <= ad_s2_reg;
         full_s1_reg  <= stack_full_i;
         full_s2_reg  <= full_s1_reg;
         pop_s1_reg   <= stack_pop_i;
         pop_s2_reg   <= pop_s1_reg;
         pop_prev_reg <= pop_s2_reg;
      end
   end

   // Highest priority is the lowest vector
   always @* begin
      fired = {ad_s2_reg & ~ad_prev_reg,
               t1_s2_reg & ~t1_prev_reg,
               t0_s2_reg & ~t0_prev_reg,
               ~ext_s2_reg & ext_prev_reg};
      // Flags record regardless of stack state
      pend_next = pend_reg | (fired & ctrl_reg[4:1]);
      take = 4'h0;
      vec  = `PMV_VEC_RESET;
      // A pop frees a level in the same cycle
      if (ctrl_reg[`PMV_CTRL_GIE] &&
          (!full_s2_reg || (pop_s2_reg && !pop_prev_reg))) begin
         if (pend_reg[0]) begin
            take = 4'h1;
            vec  = `PMV_VEC_EXT;
         end else if (pend_reg[1]) begin
            take = 4'h2;
            vec  = `PMV_VEC_TMR0;
         end else if (pend_reg[2]) begin
            take = 4'h4;
            vec  = `PMV_VEC_TMR1;
         end else if (pend_reg[3]) begin
            take = 4'h8;
            vec  = `PMV_VEC_ADC;
         end
      end
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_reg      <= ST_FETCH;
         pc_reg         <= `PMV_VEC_RESET;
         pend_reg       <= 4'h0;
         int_ack_o      <= 1'b0;
         fetch_addr_o   <= `PMV_VEC_RESET;
         fetch_word_o   <= {WORD_W{1'b0}};
         fetch_valid_o  <= 1'b0;
         tbl_high_reg   <= 8'h00;
         tbl_addr_reg   <= {PC_W{1'b0}};
         last_word_reg  <= {WORD_W{1'b0}};
         instr_pend_reg <= 1'b0;
         instr_last_reg <= 1'b0;
         instr_reg      <= 8'h00;
      end else begin
         pend_reg      <= pend_next;
         int_ack_o     <= 1'b0;
         fetch_valid_o <= 1'b0;
         if (tick && run) begin
            case (state_reg)
               ST_FETCH: begin
                  if (take != 4'h0) begin
                     // New event beats the clear of its own bit
                     pend_reg  <= (pend_reg & ~take) |
                                  (fired & ctrl_reg[4:1]);
                     int_ack_o <= 1'b1;
                     pc_reg    <= vec;
                  end else if (instr_pend_reg) begin
                     // First cycle forms the address
                     tbl_addr_reg <= {instr_last_reg ?
                        `PMV_LAST_PAGE :
                        pc_reg[11:8],
                        tbl_ptr_reg};
                     state_reg <= ST_TBL;
                  end else begin
                     fetch_addr_o  <= pc_reg;
                     fetch_word_o  <= prog_mem[pc_reg];
                     fetch_valid_o <= 1'b1;
                     pc_reg        <= pc_reg + 12'h001;
                  end
               end
               ST_TBL: begin
                  // Memory port busy, so no prefetch here
                  last_word_reg  <= prog_mem[tbl_addr_reg];
                  tbl_high_reg   <= {1'b0,
                     prog_mem[tbl_addr_reg][14:8]};
                  instr_pend_reg <= 1'b0;
                  state_reg      <= ST_FETCH;
               end
               default: state_reg <= ST_FETCH;
            endcase
         end
         // Placed last: software request set wins over completion clear
         if (wr && wb_adr_i == `PMV_OFF_INSTR && wb_sel_i[1] &&
             wb_dat_i[`PMV_INSTR_GO_BIT]) begin
            instr_pend_reg <= 1'b1;
            instr_reg      <= wb_dat_i[7:0];
            instr_last_reg <= wb_dat_i[`PMV_INSTR_LAST_BIT];
         end
      end
   end

   // Operand destination write shares the data memory port
   always @(posedge clock_i) begin
      if (tick && run && state_reg == ST_TBL &&
          instr_reg >= `PMV_SFR_END &&
          instr_reg - `PMV_SFR_END < DMEM_N)
         dmem[instr_reg - `PMV_SFR_END] <=
            prog_mem[tbl_addr_reg][7:0];
      else if (wr && wb_adr_i == `PMV_OFF_DMEM_DATA && wb_sel_i[0] &&
               gp_hit)
         dmem[gp_idx] <= wb_dat_i[7:0];
   end

   always @(posedge clock_i) begin
      if (wr && wb_adr_i == `PMV_OFF_PROG_DATA && !run)
         prog_mem[prog_addr_reg] <= wb_dat_i[WORD_W-1:0];
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl_reg      <= `PMV_CTRL_RESET;
         tbl_ptr_reg   <= 8'h00;
         prog_addr_reg <= {PC_W{1'b0}};
         dmem_addr_reg <= 8'h00;
      end else if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            `PMV_OFF_CTRL:      ctrl_reg      <= wb_dat_i[5:0];
            `PMV_OFF_TBL_PTR:   tbl_ptr_reg   <= wb_dat_i[7:0];
            `PMV_OFF_PROG_ADDR: prog_addr_reg <= wb_dat_i[PC_W-1:0];
            `PMV_OFF_DMEM_ADDR: dmem_addr_reg <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // Data memory view: SFRs first, then general area, unused read 00H
   reg [7:0] dmem_rd;
   always @* begin
      dmem_rd = 8'h00;
      if (dmem_addr_reg == `PMV_SFR_TBL_PTR)
         dmem_rd = tbl_ptr_reg;
      else if (dmem_addr_reg == `PMV_SFR_TBL_HIGH)
         dmem_rd = tbl_high_reg;
      else if (gp_hit)
         dmem_rd = dmem[gp_idx];
   end

   // One wait-free cycle: ack the edge after the request
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `PMV_OFF_CTRL:      wb_dat_o <= {26'h0, ctrl_reg};
               `PMV_OFF_STATUS:    wb_dat_o <= {26'h0, pend_reg,
                                               instr_pend_reg,
                                               state_reg[0]};
               `PMV_OFF_PC:        wb_dat_o <= {20'h0, pc_reg};
               `PMV_OFF_TBL_PTR:   wb_dat_o <= {24'h0, tbl_ptr_reg};
               `PMV_OFF_TBL_HIGH:  wb_dat_o <= {24'h0, tbl_high_reg};
               `PMV_OFF_PROG_ADDR: wb_dat_o <= {20'h0, prog_addr_reg};
               `PMV_OFF_PROG_DATA: wb_dat_o <= {17'h0,
                                               prog_mem[prog_addr_reg]};
               `PMV_OFF_DMEM_ADDR: wb_dat_o <= {24'h0, dmem_addr_reg};
               `PMV_OFF_DMEM_DATA: wb_dat_o <= {24'h0, dmem_rd};
               `PMV_OFF_INSTR:     wb_dat_o <= {22'h0, instr_pend_reg,
                                               instr_last_reg, instr_reg};
               `PMV_OFF_LAST_WORD: wb_dat_o <= {17'h0, last_word_reg};
               default:            wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// *** bench/pmv_core_sva.sv ***
// Port-level assertions for the program memory unit
`timescale 1ns/1ps
module pmv_core_chk #(
   parameter PC_W   = 12,
   parameter WORD_W = 15
) (
   input wire            clock_i,
   input wire            rst_n_i,
   input wire [7:0]      wb_adr_i,
   input wire            wb_we_i,
   input wire            wb_cyc_i,
   input wire            wb_stb_i,
   input wire [31:0]     wb_dat_o,
   input wire            wb_ack_o,
   input wire            stack_full_i,
   input wire            stack_pop_i,
   input wire            int_ack_o,
   input wire [PC_W-1:0] fetch_addr_o,
   input wire            fetch_valid_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_vec_fetch;
      fetch_valid_o && (fetch_addr_o inside {12'h004, 12'h008, 12'h00c,
                                             12'h010});
   endsequence
   bus_answer_a: assert property (s_req |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   unmapped_read_a: assert property (
      s_req and (!wb_we_i && wb_adr_i > 8'h28) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   reset_entry_a: assert property ($rose(rst_n_i) |->
      fetch_addr_o == 12'h000 && !int_ack_o && !wb_ack_o)
      else $error("reset did not restart at zero");
   int_vector_a: assert property (int_ack_o |-> ##[0:8] s_vec_fetch)
      else $error("interrupt did not fetch from a vector");
   int_pulse_a: assert property (int_ack_o |=> !int_ack_o)
      else $error("interrupt ack longer than one cycle");
   fetch_space_a: assert property (fetch_valid_o |=> !fetch_valid_o [*3])
      else $error("fetches closer than one instruction cycle");
   full_hold_a: assert property ((stack_full_i && !stack_pop_i) [*8] |-> !int_ack_o)
      else $error("interrupt taken with stack full");
   cover property (int_ack_o);
endmodule
bind pmv_core pmv_core_chk #(.PC_W(PC_W), .WORD_W(WORD_W)) chk_u (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_adr_i(wb_adr_i),
   .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stack_full_i(stack_full_i),
   .stack_pop_i(stack_pop_i), .int_ack_o(int_ack_o),
   .fetch_addr_o(fetch_addr_o), .fetch_valid_o(fetch_valid_o));

// *** bench/pmv_cpu_model.sv ***
// Core-side model: interrupt sources and stack state
`timescale 1ns/1ps
module pmv_cpu_model (
   input  wire       clock_i,
   input  wire [3:0] fire_i,
   input  wire       full_i,
   input  wire       pop_i,
   output wire       ext_int_n_o,
   output wire       tmr0_o,
   output wire       tmr1_o,
   output wire       adc_o,
   output wire       full_o,
   output wire       pop_o
);
   reg  [4:0] act_reg = 5'h00;
   reg  [3:0] age_reg [0:4];
   wire [4:0] req = {pop_i, fire_i};
   integer    i;
   initial for (i = 0; i < 5; i = i + 1) age_reg[i] = 4'h0;
   // Events held long enough to pass the input synchronisers
   always @(posedge clock_i) begin
      for (i = 0; i < 5; i = i + 1) begin
         if (req[i]) begin
            act_reg[i] <= 1'b1;
            age_reg[i] <= 4'h8;
         end
         else if (age_reg[i] != 4'h0)
            age_reg[i] <= age_reg[i] - 4'h1;
         else
            act_reg[i] <= 1'b0;
      end
   end
   assign ext_int_n_o = ~act_reg[0];
   assign tmr0_o      = act_reg[1];
   assign tmr1_o      = act_reg[2];
   assign adc_o       = act_reg[3];
   assign pop_o       = act_reg[4];
   assign full_o      = full_i;
endmodule

// *** bench/program_memory_vector_table_read_tb_top.sv ***
// Self-checking bench for the program memory unit
`timescale 1ns/1ps
`include "pmv_regs.vh"
module program_memory_vector_table_read_tb_top;
   reg         clock_i = 0, rst_n_i = 0, wb_we_i = 0, wb_cyc_i = 0;
   reg         wb_stb_i = 0, full = 0, pop = 0, hit = 0, got;
   reg  [7:0]  wb_adr_i = 0, p, d;
   reg  [31:0] wb_dat_i = 0, rd, w, o, e;
   reg  [3:0]  wb_sel_i = 0, fire = 0, win = 0;
   reg  [11:0] exp_vec = 0;
   reg  [14:0] vw, vword [0:3];
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, int_ack_o, fetch_valid_o, ext_n, t0, t1, adc;
   wire        sfull, spop;
   wire [11:0] fetch_addr_o;
   wire [14:0] fetch_word_o;
   integer     errors = 0, checked = 0, cycles = 0, k;
   pmv_core dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_int_n_i(ext_n), .tmr0_ovf_i(t0),
      .tmr1_ovf_i(t1), .adc_done_i(adc), .stack_full_i(sfull),
      .stack_pop_i(spop), .int_ack_o(int_ack_o), .fetch_addr_o(fetch_addr_o),
      .fetch_word_o(fetch_word_o), .fetch_valid_o(fetch_valid_o));
   pmv_cpu_model cpu_u (.clock_i(clock_i), .fire_i(fire), .full_i(full),
      .pop_i(pop), .ext_int_n_o(ext_n), .tmr0_o(t0), .tmr1_o(t1),
      .adc_o(adc), .full_o(sfull), .pop_o(spop));
   initial forever #5 clock_i = ~clock_i;
   task print_verdict;
      begin
         $display("checks %0d errors %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] want);
      begin
         checked = checked + 1;
         if (seen !== want) begin
            errors = errors + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask
   task wb(input we, input [7:0] a, input [31:0] dt);
      begin
         wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we;
         wb_adr_i <= a; wb_dat_i <= dt; wb_sel_i <= 4'hf;
         @(posedge clock_i);
         // Only the watchdog ends a wait for ack
         while (wb_ack_o !== 1'b1)
            @(posedge clock_i);
         rd = wb_dat_o;
         wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
         @(posedge clock_i);
      end
   endtask
   task wait_ack(input integer lim);
      integer n;
      begin
         got = 0;
         for (n = 0; n < lim; n = n + 1) begin
            @(posedge clock_i);
            if (int_ack_o === 1'b1) got = 1;
         end
      end
   endtask
   // Watchdog and vector fetch monitor
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (int_ack_o) win <= 4'h9;
      else if (win != 0) win <= win - 4'h1;
      if (fetch_valid_o && (int_ack_o || win != 0) &&
          fetch_addr_o == exp_vec) begin
         hit <= 1;
         vw  <= fetch_word_o;
      end
      if (cycles == 20000) begin
         errors = errors + 1;
         print_verdict;
      end
   end
   initial begin
      void'($urandom(32'hc827));
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1;
      @(posedge clock_i);
      wb(0, `PMV_OFF_PC, 0); chk(rd, 0);
      wb(0, 8'h3c, 0); chk(rd, 0);
      for (k = 0; k < 4; k = k + 1) begin
         p = (k > 1) ? 8'hff : $urandom;
         d = 8'h24 + $urandom % 192;
         w = $urandom & 32'h7fff;
         o = ~w & 32'h7fff;
         e = k[0] ? o : w;
         wb(1, `PMV_OFF_CTRL, 0);
         wb(1, `PMV_OFF_PROG_ADDR, {24'h0, p});
         wb(1, `PMV_OFF_PROG_DATA, w);
         wb(1, `PMV_OFF_PROG_ADDR, {20'h0, 4'hf, p});
         wb(1, `PMV_OFF_PROG_DATA, o);
         wb(1, `PMV_OFF_TBL_PTR, p);
         wb(1, `PMV_OFF_CTRL, 1);
         wb(1, `PMV_OFF_INSTR, {22'h0, 1'b1, k[0], d});
         wb(0, `PMV_OFF_STATUS, 0); chk(rd >> 1 & 32'h1, 1);
         repeat (16) @(posedge clock_i);
         wb(0, `PMV_OFF_STATUS, 0); chk(rd & 32'h3, 0);
         wb(1, `PMV_OFF_DMEM_ADDR, d);
         wb(0, `PMV_OFF_DMEM_DATA, 0); chk(rd, e & 32'hff);
         wb(0, `PMV_OFF_TBL_HIGH, 0); chk(rd, e >> 8);
         wb(0, `PMV_OFF_LAST_WORD, 0); chk(rd, e);
         wb(1, `PMV_OFF_TBL_HIGH, ~e);
         wb(0, `PMV_OFF_TBL_HIGH, 0); chk(rd, e >> 8);
         wb(1, `PMV_OFF_DMEM_DATA, w ^ 32'h5a);
         wb(0, `PMV_OFF_DMEM_DATA, 0); chk(rd, (w ^ 32'h5a) & 32'hff);
         wb(1, `PMV_OFF_DMEM_ADDR, 8'h07);
         wb(0, `PMV_OFF_DMEM_DATA, 0); chk(rd, p);
         wb(1, `PMV_OFF_DMEM_ADDR, 8'h03);
         wb(0, `PMV_OFF_DMEM_DATA, 0); chk(rd, 0);
      end
      // Vector words are loaded while stopped
      wb(1, `PMV_OFF_CTRL, 0);
      for (k = 0; k < 4; k = k + 1) begin
         vword[k] = $urandom;
         wb(1, `PMV_OFF_PROG_ADDR, 4 * (k + 1));
         wb(1, `PMV_OFF_PROG_DATA, {17'h0, vword[k]});
      end
      for (k = 0; k < 4; k = k + 1) begin
         wb(1, `PMV_OFF_CTRL, 32'h21 | (2 << k));
         full <= (k == 1);
         exp_vec <= 4 * (k + 1);
         hit <= 0;
         fire[k] <= 1;
         @(posedge clock_i);
         fire <= 0;
         wait_ack(40); chk(got, k != 1);
         if (k == 1) begin
            pop <= 1;
            full <= 0;
            @(posedge clock_i);
            pop <= 0;
            wait_ack(60); chk(got, 1);
         end
         repeat (4) @(posedge clock_i);
         chk(hit, 1);
         chk(vw, vword[k]);
      end
      wb(1, `PMV_OFF_CTRL, 32'h21);
      fire <= 4'hf;
      @(posedge clock_i);
      fire <= 0;
      wait_ack(40); chk(got, 0);
      // Second reset while running must restart at zero
      rst_n_i <= 0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1;
      @(posedge clock_i);
      wb(0, `PMV_OFF_PC, 0); chk(rd, 0);
      wb(0, `PMV_OFF_CTRL, 0); chk(rd, 0);
      print_verdict;
   end
endmodule
